// >>> dls_consts.svh
// Timing constants and link indices for the data-link supervisor.
`ifndef DLS_CONSTS_SVH
`define DLS_CONSTS_SVH

// ------------------------------------------------------------------
// Clock and time base
// ------------------------------------------------------------------
`define DLS_CLK_HZ 200000000
`define DLS_TICK_MS 100
`define DLS_TICKS_PER_S (1000 / `DLS_TICK_MS)
`define DLS_TICK_CYCLES (`DLS_CLK_HZ / 1000 * `DLS_TICK_MS)

// ------------------------------------------------------------------
// Timeouts in seconds, and in ticks of the time base
// ------------------------------------------------------------------
`define DLS_TR1_S 100
`define DLS_TR2_S 120
`define DLS_TSUP_S 15
`define DLS_TLONG_S 60
`define DLS_TC8_S 20
`define DLS_TC10_S 30
`define DLS_T(s) (11'((s) * `DLS_TICKS_PER_S))

// ------------------------------------------------------------------
// Data link indices
// ------------------------------------------------------------------
`define DLS_DL_CTRL 0
`define DLS_DL_PSTN 1
`define DLS_DL_LCTL 2
`define DLS_DL_BCC 3
`define DLS_NUM_DL 4

`endif

// >>> dls_pkg.sv
// Types shared by the data-link supervisor modules.
package dls_pkg;

  // ----------------------------------------------------------------
  // Restart procedure state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    DLS_RS_IDLE = 1'b0,
    DLS_RS_RUN = 1'b1
  } dls_rs_state_t;

  // ----------------------------------------------------------------
  // Events from one data link and its carrying C-channel
  // ----------------------------------------------------------------
  typedef struct packed {
    logic est;
    logic rel;
    logic l1_fail;
    logic flag_fail;
  } dls_link_ev_t;

  // ----------------------------------------------------------------
  // Restart primitives sent out
  // ----------------------------------------------------------------
  typedef struct packed {
    logic req_cc;
    logic req_pstn;
    logic cmp_cc;
    logic cmp_pstn;
  } dls_rst_out_t;

endpackage

// >>> dls_timer.sv
// One supervision timer counting ticks of the common time base.
`timescale 1ns/1ps

module dls_timer #(
  parameter logic [10:0] TIMEOUT_T = 11'h001
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Time base and control
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  // Status
  output logic running,
  output logic expired
);

  logic [10:0] count; // Ticks seen since start.

  // A start reloads even a running timer; start beats stop.
  // Phase error against the tick is under one tick, which keeps
  // the shortest timeout well inside its tolerance.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      running <= 1'b0;
      count <= 11'h000;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        running <= 1'b1;
        count <= 11'h000;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tick) begin
        if (count == TIMEOUT_T - 11'h001) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          count <= count + 11'h001;
        end
      end
    end
  end

endmodule

// >>> dls_supervisor.sv
// Data-link supervision, recovery timer chains and PSTN restart.
`timescale 1ns/1ps
`include "dls_consts.svh"

module dls_supervisor #(
  parameter int TICK_CYCLES = `DLS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Data link events, one entry per link index
  input wire dls_pkg::dls_link_ev_t [3:0] link_ev,
  // Startup context
  input wire logic startup_active,
  input wire logic normal_entry,
  // Restart primitives received
  input wire logic cc_rst_req,
  input wire logic cc_rst_cmp,
  input wire logic pstn_ack_all,
  // Link control outputs
  output logic [3:0] est_req,
  output logic [3:0] l1_fail_ind,
  output logic [3:0] link_up,
  // Traffic and port control outputs
  output logic stop_traffic_cc,
  output logic stop_traffic_lc,
  output logic start_traffic_cc,
  output logic start_traffic_lc,
  output logic block_isdn,
  output logic pstn_blocked,
  output logic unblock_pstn,
  output logic startup_init,
  // Restart outputs
  output dls_pkg::dls_rst_out_t rst_out,
  output logic restart_busy,
  output logic err_maint
);
  import dls_pkg::*;

  // ----------------------------------------------------------------
  // Common time base
  // ----------------------------------------------------------------

  logic [31:0] tick_cnt; // Cycles within the current tick period.
  logic tick; // One-cycle pulse every tick period.
  wire tick_wrap = (tick_cnt == 32'(TICK_CYCLES - 1));

  // A single divider feeds every timer so that all share one base;
  // a tenth of a second keeps start phase error small.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      tick <= tick_wrap;
      tick_cnt <= tick_wrap ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Startup timer TC10
  // ----------------------------------------------------------------

  logic tc10_used; // Set once TC10 was started in this startup.
  logic tc10_run; // TC10 running.
  logic tc10_exp; // TC10 expiry pulse.
  logic [3:0] est_acc; // Accepted establish events.
  wire tc10_go = startup_active & ~tc10_used & (|est_acc);
  wire tc10_stop = tc10_run & normal_entry;
  // Expiry and stop both end TC10 and judge the waiting links.
  wire tc10_end = tc10_exp | tc10_stop;

  // TC10 is armed only once per startup, by the first link.
  dls_timer #(
    .TIMEOUT_T(`DLS_T(`DLS_TC10_S))
  ) u_tc10 (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick),
    .start(tc10_go),
    .stop(normal_entry),
    .running(tc10_run),
    .expired(tc10_exp)
  );

  // The used flag rearms when startup is left.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tc10_used <= 1'b0;
    end else if (!startup_active) begin
      tc10_used <= 1'b0;
    end else if (tc10_go) begin
      tc10_used <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Per-link supervision
  // ----------------------------------------------------------------

  logic [3:0] down; // Link failed and waiting for recovery.
  logic [3:0] phys_q; // Previous layer-1 or flag failure level.
  logic [3:0] fail_ev; // Link failure detected this cycle.
  logic [3:0] recover; // Establish after a failure.
  logic [3:0] phys; // Layer-1 or flag failure, as a level.
  logic [3:0] l1_rise; // Layer-1 or flag failure appeared.
  logic [3:0] sup_exp; // First-stage timer (TC1/3/4/6) expired.
  logic [3:0] st2_exp; // Second-stage timer (TC2/5/7) expired.

  genvar i;
  for (i = 0; i < `DLS_NUM_DL; i++) begin : g_link
    wire est_ev = link_ev[i].est;
    wire rel_ev = link_ev[i].rel;

    assign phys[i] = link_ev[i].l1_fail | link_ev[i].flag_fail;
    assign l1_rise[i] = phys[i] & ~phys_q[i];
    // An establish for a link already up changes nothing.
    assign est_acc[i] = est_ev & ~link_up[i];
    assign recover[i] = est_acc[i] & down[i];
    // Established links fail on release or lost carrier.
    // Links still waiting at the end of TC10 fail too.
    assign fail_ev[i] = (link_up[i] & (rel_ev | l1_rise[i])) |
                        (tc10_end & ~link_up[i] & ~down[i]);

    // Up and down flags; a failure and a recovery are exclusive
    // because they need the link in opposite conditions.
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        link_up[i] <= 1'b0;
        down[i] <= 1'b0;
        phys_q[i] <= 1'b0;
      end else begin
        phys_q[i] <= phys[i];
        if (fail_ev[i]) begin
          link_up[i] <= 1'b0;
          down[i] <= 1'b1;
        end else if (est_acc[i]) begin
          link_up[i] <= 1'b1;
          down[i] <= 1'b0;
        end
      end
    end

    // First-stage 15 s timer, stopped by recovery.
    dls_timer #(
      .TIMEOUT_T(`DLS_T(`DLS_TSUP_S))
    ) u_sup (
      .clk_sys(clk_sys),
      .rst(rst),
      .tick(tick),
      .start(fail_ev[i]),
      .stop(recover[i]),
      .running(),
      .expired(sup_exp[i])
    );

    // The PSTN link has no second stage; its first stage blocks.
    if (i != `DLS_DL_PSTN) begin : g_st2
      // One-minute stage after the first expires.
      dls_timer #(
        .TIMEOUT_T(`DLS_T(`DLS_TLONG_S))
      ) u_st2 (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .start(sup_exp[i]),
        .stop(recover[i]),
        .running(),
        .expired(st2_exp[i])
      );
    end else begin : g_no_st2
      assign st2_exp[i] = 1'b0;
    end
  end

  // Retry each failed link once per tick, but never while its
  // carrier or flag monitor is down.
  wire [3:0] next_est_req = down & ~phys & {4{tick}};
  // Halt the link at once when its carrier goes.
  wire [3:0] next_l1_ind = l1_rise & (link_up | down);

  // ----------------------------------------------------------------
  // Final timer TC8 and startup trigger
  // ----------------------------------------------------------------

  logic tc8_exp; // TC8 expiry pulse.
  wire tc8_go = |st2_exp;

  // TC8 has no stop; a fresh start only reloads it.
  dls_timer #(
    .TIMEOUT_T(`DLS_T(`DLS_TC8_S))
  ) u_tc8 (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick),
    .start(tc8_go),
    .stop(1'b0),
    .running(),
    .expired(tc8_exp)
  );

  // ----------------------------------------------------------------
  // Traffic control for the control and link-control links
  // ----------------------------------------------------------------

  logic cc_stopped; // Control protocols were stopped.
  logic lc_stopped; // Link-control protocols were stopped.
  wire cc_exp = sup_exp[`DLS_DL_CTRL];
  wire lc_exp = sup_exp[`DLS_DL_LCTL];
  wire cc_back = recover[`DLS_DL_CTRL] & cc_stopped;
  wire lc_back = recover[`DLS_DL_LCTL] & lc_stopped;

  // Remember stopped traffic so that recovery can restart it.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cc_stopped <= 1'b0;
      lc_stopped <= 1'b0;
    end else begin
      cc_stopped <= cc_exp | (cc_stopped & ~cc_back);
      lc_stopped <= lc_exp | (lc_stopped & ~lc_back);
    end
  end

  // ----------------------------------------------------------------
  // PSTN restart procedure
  // ----------------------------------------------------------------

  dls_rs_state_t rs_state; // Restart procedure state.
  dls_rs_state_t next_rs_state; // Next restart procedure state.
  logic peer_done; // Peer reported restart complete.
  logic local_done; // Local FSMs done, or TR1 gave up.
  logic tr1_run; // TR1 running.
  logic tr2_run; // TR2 running.
  logic tr1_exp; // TR1 expiry pulse.
  logic tr2_exp; // TR2 expiry pulse.

  wire rs_idle = (rs_state == DLS_RS_IDLE);
  // Local start: PSTN link back after its failure.
  wire start_loc = rs_idle & recover[`DLS_DL_PSTN];
  // Peer start only when no restart runs; else ignored.
  wire start_peer = rs_idle & cc_rst_req & ~start_loc;
  wire rs_start = start_loc | start_peer;
  // Stray completes and acks are dropped.
  wire peer_in = cc_rst_cmp & tr2_run;
  wire ack_in = pstn_ack_all & tr1_run;
  wire loc_now = local_done | ack_in | tr1_exp;
  wire peer_now = peer_done | peer_in;
  // Finish when both sides are done, or TR2 gives up.
  wire rs_fin = ~rs_idle & (tr2_exp | (loc_now & peer_now));

  // TR1 guards the local acknowledgements.
  dls_timer #(
    .TIMEOUT_T(`DLS_T(`DLS_TR1_S))
  ) u_tr1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick),
    .start(rs_start),
    .stop(ack_in | rs_fin),
    .running(tr1_run),
    .expired(tr1_exp)
  );

  // TR2 guards the peer completion.
  dls_timer #(
    .TIMEOUT_T(`DLS_T(`DLS_TR2_S))
  ) u_tr2 (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick),
    .start(rs_start),
    .stop(peer_in | rs_fin),
    .running(tr2_run),
    .expired(tr2_exp)
  );

  // Only one procedure at a time; the end returns to idle.
  always_comb begin
    case (rs_state)
      DLS_RS_IDLE: next_rs_state = rs_start ? DLS_RS_RUN : DLS_RS_IDLE;
      DLS_RS_RUN: next_rs_state = rs_fin ? DLS_RS_IDLE : DLS_RS_RUN;
      default: next_rs_state = DLS_RS_IDLE;
    endcase
  end

  // State and completion flags; the flags clear at start and end.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rs_state <= DLS_RS_IDLE;
      peer_done <= 1'b0;
      local_done <= 1'b0;
    end else begin
      rs_state <= next_rs_state;
      peer_done <= ~rs_fin & ~rs_start & peer_now;
      local_done <= ~rs_fin & ~rs_start & loc_now;
    end
  end

  // Outgoing restart primitives, each a one-cycle pulse.
  dls_rst_out_t next_rst_out;
  assign next_rst_out.req_cc = start_loc;
  assign next_rst_out.req_pstn = rs_start;
  assign next_rst_out.cmp_cc = ack_in | tr1_exp;
  assign next_rst_out.cmp_pstn = rs_fin;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------

  // PSTN ports stay blocked until a restart finishes.
  wire next_pstn_blocked = sup_exp[`DLS_DL_PSTN] |
                           (pstn_blocked & ~rs_fin);

  // Every output leaves a flip-flop; pulses last one cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      est_req <= 4'h0;
      l1_fail_ind <= 4'h0;
      stop_traffic_cc <= 1'b0;
      stop_traffic_lc <= 1'b0;
      start_traffic_cc <= 1'b0;
      start_traffic_lc <= 1'b0;
      block_isdn <= 1'b0;
      pstn_blocked <= 1'b0;
      unblock_pstn <= 1'b0;
      startup_init <= 1'b0;
      rst_out <= '0;
      restart_busy <= 1'b0;
      err_maint <= 1'b0;
    end else begin
      est_req <= next_est_req;
      l1_fail_ind <= next_l1_ind;
      stop_traffic_cc <= cc_exp;
      stop_traffic_lc <= lc_exp;
      start_traffic_cc <= cc_back;
      start_traffic_lc <= lc_back;
      block_isdn <= cc_exp;
      pstn_blocked <= next_pstn_blocked;
      // A fresh block in the same cycle wins over the unblock.
      unblock_pstn <= pstn_blocked & rs_fin & ~sup_exp[`DLS_DL_PSTN];
      startup_init <= tc8_exp;
      rst_out <= next_rst_out;
      restart_busy <= (next_rs_state == DLS_RS_RUN);
      err_maint <= tr1_exp | tr2_exp;
    end
  end

endmodule

// >>> dls_supervisor_props.sv
// Concurrent checks on the ports of the data-link supervisor.
`timescale 1ns/1ps

module dls_supervisor_props #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Inputs of the block
  input wire dls_pkg::dls_link_ev_t [3:0] link_ev,
  input wire logic cc_rst_req,
  input wire logic cc_rst_cmp,
  // Outputs of the block
  input wire logic [3:0] est_req,
  input wire logic [3:0] link_up,
  input wire logic stop_traffic_cc,
  input wire logic block_isdn,
  input wire logic pstn_blocked,
  input wire logic unblock_pstn,
  input wire logic startup_init,
  input wire dls_pkg::dls_rst_out_t rst_out,
  input wire logic restart_busy,
  input wire logic err_maint
);
  import dls_pkg::*;

  // ----------------------------------------------------------------
  // Per-link views of the event struct
  // ----------------------------------------------------------------
  logic [3:0] rel_v; // Release pulses.
  logic [3:0] bad_v; // Carrier down: layer 1 or flag failure.

  // Flatten the struct so that link masks can be compared at once.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rel_v[i] = link_ev[i].rel;
      bad_v[i] = link_ev[i].l1_fail | link_ev[i].flag_fail;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Restart procedure
  // ----------------------------------------------------------------
  a_peer_req_fwd: assert property (cc_rst_req && !restart_busy
    |=> rst_out.req_pstn && restart_busy) else $error("peer req lost");
  a_busy_req_drop: assert property (restart_busy && cc_rst_req
    |=> !rst_out.req_pstn) else $error("req taken while busy");
  a_stray_cmp: assert property (!restart_busy && cc_rst_cmp
    |=> !rst_out.cmp_pstn) else $error("stray complete used");
  a_local_pair: assert property (rst_out.req_cc
    |-> rst_out.req_pstn && restart_busy) else $error("local req split");
  a_end_idle: assert property (rst_out.cmp_pstn
    |-> !restart_busy && $past(restart_busy)) else $error("end not idle");
  a_err_cmp: assert property (err_maint
    |-> rst_out.cmp_cc || rst_out.cmp_pstn) else $error("error alone");

  // ----------------------------------------------------------------
  // Link supervision
  // ----------------------------------------------------------------
  a_rel_down: assert property ((link_up & rel_v) != 4'h0
    |=> (link_up & $past(link_up & rel_v)) == 4'h0)
    else $error("released link stays up");
  // Two cycles of history allow for a registered failure flag.
  a_halt_retry: assert property (
    (est_req & $past(bad_v) & $past(bad_v, 2)) == 4'h0)
    else $error("retry while carrier down");
  a_tc1_block: assert property (stop_traffic_cc |-> block_isdn)
    else $error("stop traffic without block");
  a_blk_unblk: assert property (unblock_pstn
    |-> !pstn_blocked && $past(pstn_blocked)) else $error("bad unblock");

  c_restart_end: cover property (rst_out.cmp_pstn && rst_out.cmp_cc);
  c_startup: cover property (startup_init);
  c_unblock: cover property (unblock_pstn);
endmodule

bind dls_supervisor dls_supervisor_props #(
  .TICK_CYCLES(TICK_CYCLES)
) u_props (
  .clk_sys(clk_sys),
  .rst(rst),
  .link_ev(link_ev),
  .cc_rst_req(cc_rst_req),
  .cc_rst_cmp(cc_rst_cmp),
  .est_req(est_req),
  .link_up(link_up),
  .stop_traffic_cc(stop_traffic_cc),
  .block_isdn(block_isdn),
  .pstn_blocked(pstn_blocked),
  .unblock_pstn(unblock_pstn),
  .startup_init(startup_init),
  .rst_out(rst_out),
  .restart_busy(restart_busy),
  .err_maint(err_maint)
);

// >>> dls_far_end.sv
// Far-side model: data links and the local PSTN protocol FSMs.
`timescale 1ns/1ps

module dls_far_end (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Requests from the supervisor
  input wire logic [3:0] est_req,
  input wire dls_pkg::dls_rst_out_t rst_out,
  // Behaviour chosen by the bench
  input wire logic [3:0] ena,
  input wire logic ack_ena,
  input wire logic [7:0] dly,
  input wire logic [7:0] ack_dly,
  // Answers
  output logic [3:0] est_o,
  output logic ack_o
);
  import dls_pkg::*;

  logic [7:0] cnt [4]; // Establish delay per link.
  logic [7:0] acnt; // Acknowledge delay.

  // Answers change on the falling edge, away from the sampling edge.
  // A disabled link stays silent, so its supervision timer runs out.
  always @(negedge clk_sys) begin
    est_o <= 4'h0;
    ack_o <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (rst) begin
        cnt[i] <= 8'h00;
      end else if (cnt[i] != 8'h00) begin
        cnt[i] <= cnt[i] - 8'h01;
      end else if (est_req[i] && ena[i]) begin
        cnt[i] <= dly;
      end
      if (cnt[i] == 8'h01) begin
        est_o[i] <= 1'b1;
      end
    end
    if (rst) begin
      acnt <= 8'h00;
    end else if (acnt != 8'h00) begin
      acnt <= acnt - 8'h01;
    end else if (rst_out.req_pstn && ack_ena) begin
      acnt <= ack_dly;
    end
    if (acnt == 8'h01) begin
      ack_o <= 1'b1;
    end
  end
endmodule

// >>> dls_supervisor_tb.sv
// Self-checking bench for the data-link supervisor.
`timescale 1ns/1ps

module dls_supervisor_tb;
  import dls_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int TC = 10; // Short tick keeps the run brief.
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] est_tb = 4'h0, rel = 4'h0, l1 = 4'h0, flg = 4'h0, ena = 4'h0;
  logic [3:0] est_far, est_req, l1_fail_ind, link_up;
  logic startup_active = 1'b0, normal_entry = 1'b0, cc_rst_req = 1'b0;
  logic cc_rst_cmp = 1'b0, ack_tb = 1'b0, ack_far, ack_ena = 1'b0;
  logic [7:0] dly = 8'h01, ack_dly = 8'h02;
  logic stop_traffic_cc, start_traffic_cc, block_isdn, pstn_blocked;
  logic stop_traffic_lc, start_traffic_lc;
  logic unblock_pstn, startup_init, restart_busy, err_maint;
  logic [31:0] seed = 32'h00011796;
  int bad_count = 0, n_compared = 0, cyc = 0, dt, t;
  dls_link_ev_t [3:0] link_ev;
  dls_rst_out_t rst_out;
  wire [6:0] obs = {unblock_pstn, start_traffic_cc, startup_init,
    stop_traffic_cc, pstn_blocked, err_maint, rst_out.req_cc};

  always #2.5 clk_sys = ~clk_sys;

  // Merge bench and far-side establish pulses into the event struct.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      link_ev[i] = '{est_tb[i] | est_far[i], rel[i], l1[i], flg[i]};
    end
  end

  dls_supervisor #(.TICK_CYCLES(TC)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .link_ev(link_ev),
    .startup_active(startup_active), .normal_entry(normal_entry),
    .cc_rst_req(cc_rst_req), .cc_rst_cmp(cc_rst_cmp),
    .pstn_ack_all(ack_tb | ack_far), .est_req(est_req),
    .l1_fail_ind(l1_fail_ind), .link_up(link_up),
    .stop_traffic_cc(stop_traffic_cc), .stop_traffic_lc(stop_traffic_lc),
    .start_traffic_cc(start_traffic_cc), .start_traffic_lc(start_traffic_lc),
    .block_isdn(block_isdn), .pstn_blocked(pstn_blocked),
    .unblock_pstn(unblock_pstn), .startup_init(startup_init),
    .rst_out(rst_out), .restart_busy(restart_busy), .err_maint(err_maint)
  );

  dls_far_end u_far (
    .clk_sys(clk_sys), .rst(rst), .est_req(est_req), .rst_out(rst_out),
    .ena(ena), .ack_ena(ack_ena), .dly(dly), .ack_dly(ack_dly),
    .est_o(est_far), .ack_o(ack_far)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Wait a bounded time for one observed pulse or level.
  task wt(input int b, input int lim);
    dt = 0;
    do begin
      @(negedge clk_sys);
      dt++;
    end while (obs[b] !== 1'b1 && dt < lim);
    chk("wait", obs[b], 1'b1);
  endtask

  // Timeouts must land within five percent of nominal.
  task rng(input string nm, input int ticks);
    chk(nm, dt >= ticks * TC * 95 / 100 && dt <= ticks * TC * 105 / 100, 1);
  endtask

  task final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    startup_active = 1'b1;
    est_tb = 4'hf;
    @(negedge clk_sys);
    est_tb = 4'h0;
    normal_entry = 1'b1;
    @(negedge clk_sys);
    normal_entry = 1'b0;
    startup_active = 1'b0;
    chk("link_up", link_up, 4'hf);
    est_tb = 4'hf;
    @(negedge clk_sys);
    est_tb = 4'h0;
    @(negedge clk_sys);
    chk("link_up", link_up, 4'hf);
    // Peer restart: local acks first, then peer first.
    for (int i = 0; i < 2; i++) begin
      cc_rst_req = 1'b1;
      @(negedge clk_sys);
      chk("req_pstn", rst_out.req_pstn, 1'b1);
      chk("req_cc", rst_out.req_cc, 1'b0);
      @(negedge clk_sys);
      cc_rst_req = 1'b0;
      chk("req_pstn", rst_out.req_pstn, 1'b0);
      repeat (xs() % 8) @(negedge clk_sys);
      if (i == 0) ack_tb = 1'b1; else cc_rst_cmp = 1'b1;
      @(negedge clk_sys);
      ack_tb = 1'b0;
      cc_rst_cmp = 1'b0;
      chk("cmp_cc", rst_out.cmp_cc, i == 0);
      chk("busy", restart_busy, 1'b1);
      if (i == 0) cc_rst_cmp = 1'b1; else ack_tb = 1'b1;
      @(negedge clk_sys);
      ack_tb = 1'b0;
      cc_rst_cmp = 1'b0;
      chk("cmp_cc", rst_out.cmp_cc, i == 1);
      chk("cmp_pstn", rst_out.cmp_pstn, 1'b1);
      chk("busy", restart_busy, 1'b0);
    end
    cc_rst_cmp = 1'b1;
    ack_tb = 1'b1;
    @(negedge clk_sys);
    cc_rst_cmp = 1'b0;
    ack_tb = 1'b0;
    chk("rst_out", rst_out, 4'h0);
    // PSTN link drops and returns; nobody answers the restart.
    dly = 8'h01 + 8'(xs() % 4);
    ena = 4'h2;
    rel = 4'h2;
    @(negedge clk_sys);
    rel = 4'h0;
    chk("link_up", link_up, 4'hd);
    wt(0, 100);
    chk("req_pstn", rst_out.req_pstn, 1'b1);
    wt(1, 11000);
    rng("tr1", 1000);
    chk("cmp_cc", rst_out.cmp_cc, 1'b1);
    chk("cmp_pstn", rst_out.cmp_pstn, 1'b0);
    t = dt;
    wt(1, 3000);
    dt = dt + t;
    rng("tr2", 1200);
    chk("cmp_pstn", rst_out.cmp_pstn, 1'b1);
    chk("busy", restart_busy, 1'b0);
    // PSTN link stays down past its supervision time.
    ena = 4'h0;
    rel = 4'h2;
    @(negedge clk_sys);
    rel = 4'h0;
    wt(2, 2000);
    rng("tc3", 150);
    ena = 4'h2;
    ack_ena = 1'b1;
    ack_dly = 8'h02 + 8'(xs() % 16);
    wt(0, 100);
    cc_rst_cmp = 1'b1;
    @(negedge clk_sys);
    cc_rst_cmp = 1'b0;
    wt(6, 100);
    chk("blocked", pstn_blocked, 1'b0);
    ack_ena = 1'b0;
    // Control and link-control links lost, bearer carrier lost.
    ena = 4'h0;
    rel = 4'h5;
    if (xs() % 2) l1 = 4'h8; else flg = 4'h8;
    @(negedge clk_sys);
    rel = 4'h0;
    chk("l1_ind", l1_fail_ind, 4'h8);
    chk("link_up", link_up, 4'h2);
    wt(3, 2000);
    rng("tc1", 150);
    chk("block_isdn", block_isdn, 1'b1);
    chk("stop_lc", stop_traffic_lc, 1'b1);
    wt(4, 9000);
    rng("tc2_tc8", 800);
    l1 = 4'h0;
    flg = 4'h0;
    ena = 4'hd;
    wt(5, 200);
    chk("link_up0", link_up[0], 1'b1);
    chk("start_lc", start_traffic_lc, 1'b1);
    final_report();
  end
endmodule
